// ===== dpc_dma_config.sv
// How it works
// (R01) Transfer width bit: 0 byte-wide, 1 word-wide, for both DMA channels.
// (R02) Word mode reaches 32k words and holds the lowest address line low.
// (R03) Byte order 0 puts MS byte on upper lanes; 1 swaps the lanes.
// (R04) Byte order setting is ignored while transfers are byte-wide.
// (R05) Long address 1 drives the remote start address on address bits 16-31.
// (R06) Long address bit comes out of reset set.
// (R07) Loopback select 0 enables loopback, using the transmit loop mode bits.
// (R08) Auto-init bit 1 executes send command; 0 refuses it.
// (R09) Reversed-byte-order hosts never use send; they remove packets by program.
// (R10) Receive bus request at FIFO threshold 2, 4, 8 or 12 bytes.
// (R11) Transmit request threshold is thirteen bytes minus receive threshold.
// (R12) Burst length on the system bus follows the threshold setting.
// (R13) Host writes data path configuration before the remote byte count.
// (R14) Loop modes: normal, internal, encoder loop with loop pin, external.
// (R15) Bit 7 of data path configuration is unused and not stored.
`timescale 1ns/1ps
`default_nettype none
module dpc_dma_config
    import dpc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rxActive,
    input  wire logic        txActive,
    input  wire logic [4:0]  fifoLevel,
    input  wire logic [7:0]  fifoMsByte,
    input  wire logic [7:0]  fifoLsByte,
    input  wire logic [15:0] dmaAddr,
    input  wire logic        busGrantPin,
    output logic             busRequest,
    output logic      [31:0] busAddr,
    output logic      [15:0] busData,
    output logic             wordMode,
    output logic             transferStrobe,
    output logic             burstDone,
    output logic      [1:0]  loopMode,
    output logic             loopPin,
    output logic             remoteAutoInit
);

    // Bus address phase capture.
    logic        wrPend_q;
    logic [5:0]  wrIdx_q;
    logic [31:0] rdData_q;

    // Programmed state.
    logic [6:0]  dataPathCfg_q;
    logic [1:0]  txLoopMode_q;
    logic [15:0] remoteStart_q;
    logic [15:0] remoteCount_q;
    logic        cfgWritten_q;
    logic        sendReject_q;
    logic        orderError_q;
    logic        autoInit_q;

    // Grant synchroniser and burst engine.
    logic        grantMeta_q;
    logic        grantSync_q;
    dpc_state_t  state_q;
    logic [3:0]  beatCount_q;
    logic        burstDone_q;
    logic [31:0] busAddr_q;
    logic [15:0] busData_q;

    // Derived configuration.
    logic        swapLanes;
    logic        longAddr;
    logic        autoRemote;
    logic [1:0]  thrCode;
    logic [4:0]  rxThrBytes;
    logic [4:0]  txThrBytes;
    logic [3:0]  burstLength;
    logic        rxWant;
    logic        txWant;
    logic [31:0] statusWord;
    logic        addrPhase;

    function automatic logic hit(input logic [5:0] idx,
                                 input logic [5:0] target);
        hit = (idx == target);
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdData_q;
    assign addrPhase = hsel && htrans[1] && hready;

    assign wordMode   = dataPathCfg_q[BIT_WORD_TRANSFER]; // (R01)
    assign swapLanes  = wordMode
                        && dataPathCfg_q[BIT_BYTE_ORDER]; // (R04)
    assign longAddr   = dataPathCfg_q[BIT_LONG_ADDRESS];
    assign autoRemote = dataPathCfg_q[BIT_AUTO_REMOTE];
    assign thrCode    = {dataPathCfg_q[BIT_FIFO_THR_HI],
                         dataPathCfg_q[BIT_FIFO_THR_LO]};

    dpc_fifo_threshold u_threshold (
        .thrCode     (thrCode),
        .wordMode    (wordMode),
        .rxThrBytes  (rxThrBytes),
        .txThrBytes  (txThrBytes),
        .burstLength (burstLength)
    );

    // Loopback only when selected; loop pin follows encoder loopback.
    always_comb begin
        if (!dataPathCfg_q[BIT_LOOP_SELECT]) begin // (R07)
            loopMode = txLoopMode_q;
        end else begin
            loopMode = LOOP_NORMAL;
        end
        loopPin = (loopMode == LOOP_ENCODER); // (R14)
    end

    assign rxWant = rxActive && (fifoLevel >= rxThrBytes); // (R10)
    assign txWant = txActive && (fifoLevel <= txThrBytes); // (R11)

    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[BIT_ST_REQUEST]     = busRequest;
        statusWord[BIT_ST_BURST]       = (state_q == ST_BURST);
        statusWord[BIT_ST_SEND_REJECT] = sendReject_q;
        statusWord[BIT_ST_ORDER_ERROR] = orderError_q;
        statusWord[POS_ST_BURST_LEN +: 4] = burstLength;
        statusWord[POS_ST_RX_THR +: 5]    = rxThrBytes;
        statusWord[POS_ST_TX_THR +: 5]    = txThrBytes;
        statusWord[POS_ST_LOOP_MODE +: 2] = loopMode;
    end

    // Address phase capture; writes complete in the data phase.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrIdx_q  <= 6'h00;
        end else begin
            wrPend_q <= addrPhase && hwrite;
            if (addrPhase) begin
                wrIdx_q <= haddr[7:2];
            end
        end
    end

    // Read data is registered at the address phase edge.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData_q <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            if (hit(haddr[7:2], IDX_STATUS) && haddr[31:8] == 24'h000000) begin
                rdData_q <= statusWord;
            end else if (hit(haddr[7:2], IDX_REMOTE_START)
                         && haddr[31:8] == 24'h000000) begin
                rdData_q <= {16'h0000, remoteStart_q};
            end else if (hit(haddr[7:2], IDX_REMOTE_COUNT)
                         && haddr[31:8] == 24'h000000) begin
                rdData_q <= {16'h0000, remoteCount_q};
            end else begin
                rdData_q <= 32'h0000_0000;
            end
        end
    end

    // Configuration registers; bit 7 is not stored.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dataPathCfg_q <= DATA_PATH_CFG_RESET; // (R06)
            cfgWritten_q  <= 1'b0;
        end else if (wrPend_q && hit(wrIdx_q, IDX_DATA_PATH_CFG)) begin
            dataPathCfg_q <= hwdata[6:0]; // (R15)
            cfgWritten_q  <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            txLoopMode_q <= LOOP_MODE_RESET;
        end else if (wrPend_q && hit(wrIdx_q, IDX_TRANSMIT_CFG)) begin
            txLoopMode_q <= {hwdata[BIT_LOOP_MODE_HI],
                             hwdata[BIT_LOOP_MODE_LO]}; // (R14)
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            remoteStart_q <= REMOTE_START_RESET;
        end else if (wrPend_q && hit(wrIdx_q, IDX_REMOTE_START)) begin
            remoteStart_q <= hwdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            remoteCount_q <= REMOTE_COUNT_RESET;
        end else if (wrPend_q && hit(wrIdx_q, IDX_REMOTE_COUNT)) begin
            remoteCount_q <= hwdata[15:0];
        end
    end

    // Count written before configuration is flagged; set wins over clear.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            orderError_q <= 1'b0;
        end else if (wrPend_q && hit(wrIdx_q, IDX_REMOTE_COUNT)
                     && !cfgWritten_q) begin
            orderError_q <= 1'b1; // (R13)
        end else if (wrPend_q && hit(wrIdx_q, IDX_STATUS)
                     && hwdata[BIT_ST_ORDER_ERROR]) begin
            orderError_q <= 1'b0;
        end
    end

    // Send command runs only with auto-init remote enabled.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            autoInit_q   <= 1'b0;
            sendReject_q <= 1'b0;
        end else begin
            autoInit_q <= wrPend_q && hit(wrIdx_q, IDX_COMMAND)
                          && hwdata[BIT_SEND_COMMAND] && autoRemote; // (R08)
            if (wrPend_q && hit(wrIdx_q, IDX_COMMAND)
                && hwdata[BIT_SEND_COMMAND] && !autoRemote) begin
                sendReject_q <= 1'b1; // (R08)
            end else if (wrPend_q && hit(wrIdx_q, IDX_STATUS)
                         && hwdata[BIT_ST_SEND_REJECT]) begin
                sendReject_q <= 1'b0;
            end
        end
    end

    assign remoteAutoInit = autoInit_q;

    // Grant arrives from a pin.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            grantMeta_q <= 1'b0;
            grantSync_q <= 1'b0;
        end else begin
            grantMeta_q <= busGrantPin;
            grantSync_q <= grantMeta_q;
        end
    end

    // Request, wait for grant, then run one burst.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            beatCount_q <= 4'h0;
            burstDone_q <= 1'b0;
        end else begin
            burstDone_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (rxWant || txWant) begin
                        state_q <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    beatCount_q <= 4'h0;
                    if (!rxActive && !txActive) begin
                        state_q <= ST_IDLE;
                    end else if (grantSync_q) begin
                        state_q <= ST_BURST;
                    end
                end
                ST_BURST: begin
                    beatCount_q <= beatCount_q + 4'h1;
                    if (beatCount_q == burstLength - 4'h1) begin // (R12)
                        state_q     <= ST_IDLE;
                        burstDone_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign busRequest     = (state_q != ST_IDLE); // (R10) (R11)
    assign transferStrobe = (state_q == ST_BURST);
    assign burstDone      = burstDone_q;

    // Address and data lanes are registered.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busAddr_q <= 32'h0000_0000;
        end else begin
            if (longAddr) begin
                busAddr_q[31:16] <= remoteStart_q; // (R05)
            end else begin
                busAddr_q[31:16] <= 16'h0000; // (R05)
            end
            if (wordMode) begin
                busAddr_q[15:0] <= {dmaAddr[15:1], 1'b0}; // (R02)
            end else begin
                busAddr_q[15:0] <= dmaAddr;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busData_q <= 16'h0000;
        end else if (!wordMode) begin
            busData_q <= {8'h00, fifoLsByte}; // (R01)
        end else if (swapLanes) begin
            busData_q <= {fifoLsByte, fifoMsByte}; // (R03)
        end else begin
            busData_q <= {fifoMsByte, fifoLsByte}; // (R03)
        end
    end

    assign busAddr = busAddr_q;
    assign busData = busData_q;

endmodule
`default_nettype wire

// ===== dpc_pkg.sv
package dpc_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_COMMAND        = 6'h00;
    localparam logic [5:0] IDX_REMOTE_START   = 6'h08;
    localparam logic [5:0] IDX_REMOTE_COUNT   = 6'h0A;
    localparam logic [5:0] IDX_TRANSMIT_CFG   = 6'h0D;
    localparam logic [5:0] IDX_DATA_PATH_CFG  = 6'h0E;
    localparam logic [5:0] IDX_STATUS         = 6'h10;

    // Data path configuration fields.
    localparam int BIT_WORD_TRANSFER  = 0;
    localparam int BIT_BYTE_ORDER     = 1;
    localparam int BIT_LONG_ADDRESS   = 2;
    localparam int BIT_LOOP_SELECT    = 3;
    localparam int BIT_AUTO_REMOTE    = 4;
    localparam int BIT_FIFO_THR_LO    = 5;
    localparam int BIT_FIFO_THR_HI    = 6;
    localparam logic [6:0] DATA_PATH_CFG_RESET = 7'h04;

    // Transmit configuration loop mode field.
    localparam int BIT_LOOP_MODE_LO   = 1;
    localparam int BIT_LOOP_MODE_HI   = 2;
    localparam logic [1:0] LOOP_MODE_RESET = 2'h0;

    // Command and status fields.
    localparam int BIT_SEND_COMMAND   = 0;
    localparam int BIT_ST_REQUEST     = 0;
    localparam int BIT_ST_BURST       = 1;
    localparam int BIT_ST_SEND_REJECT = 2;
    localparam int BIT_ST_ORDER_ERROR = 3;
    localparam int POS_ST_BURST_LEN   = 4;
    localparam int POS_ST_RX_THR      = 8;
    localparam int POS_ST_TX_THR      = 16;
    localparam int POS_ST_LOOP_MODE   = 24;

    localparam logic [15:0] REMOTE_START_RESET = 16'h0000;
    localparam logic [15:0] REMOTE_COUNT_RESET = 16'h0000;

    // FIFO sizing in bytes.
    localparam logic [4:0] FIFO_BYTES     = 5'h10;
    localparam logic [4:0] TX_BASE_BYTES  = 5'h0D;

    typedef enum logic [1:0] {
        LOOP_NORMAL   = 2'b00,
        LOOP_INTERNAL = 2'b01,
        LOOP_ENCODER  = 2'b10,
        LOOP_EXTERNAL = 2'b11
    } dpc_loop_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_REQ   = 2'b01,
        ST_BURST = 2'b10
    } dpc_state_t;

endpackage

// ===== dpc_fifo_threshold.sv
`timescale 1ns/1ps
`default_nettype none
module dpc_fifo_threshold
    import dpc_pkg::*;
(
    input  wire logic [1:0] thrCode,
    input  wire logic       wordMode,
    output logic      [4:0] rxThrBytes,
    output logic      [4:0] txThrBytes,
    output logic      [3:0] burstLength
);

    // Bytes the FIFO must hold for a given code; equal in both widths.
    function automatic logic [4:0] codeBytes(input logic [1:0] code);
        case (code)
            2'b00:   codeBytes = 5'h02;
            2'b01:   codeBytes = 5'h04;
            2'b10:   codeBytes = 5'h08;
            2'b11:   codeBytes = 5'h0C;
            default: codeBytes = 5'h02;
        endcase
    endfunction

    logic [4:0] thrBytes;

    always_comb begin
        thrBytes   = codeBytes(thrCode);
        rxThrBytes = thrBytes; // (R10)
        txThrBytes = TX_BASE_BYTES - thrBytes; // (R11)
        // Burst counts transfers: words in word mode, bytes otherwise.
        if (wordMode) begin // (R12)
            burstLength = thrBytes[4:1];
        end else begin
            burstLength = thrBytes[3:0];
        end
    end

endmodule
`default_nettype wire

// ===== dpc_bus_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module dpc_bus_arbiter (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       busRequest,
    input  wire logic [3:0] grantDelay,
    output logic            busGrantPin
);
    logic [3:0] waitCnt_q;

    // Grants after a chosen delay and withdraws once the request falls.
    always_ff @(posedge core_clk) begin
        if (rst || !busRequest) begin
            waitCnt_q   <= 4'h0;
            busGrantPin <= 1'b0;
        end else if (waitCnt_q >= grantDelay) begin
            busGrantPin <= 1'b1;
        end else begin
            waitCnt_q <= waitCnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== dpc_dma_config_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dpc_dma_config_monitor (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        rxActive,
    input  wire logic        txActive,
    input  wire logic [4:0]  fifoLevel,
    input  wire logic        busGrantPin,
    input  wire logic        busRequest,
    input  wire logic [31:0] busAddr,
    input  wire logic [15:0] busData,
    input  wire logic        wordMode,
    input  wire logic        transferStrobe,
    input  wire logic        burstDone,
    input  wire logic [1:0]  loopMode,
    input  wire logic        loopPin,
    input  wire logic        remoteAutoInit
);
    logic [3:0] runCnt_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Counts the beats already seen in the current burst.
    always_ff @(posedge core_clk) begin
        if (rst || !transferStrobe) begin
            runCnt_q <= 4'h0;
        end else begin
            runCnt_q <= runCnt_q + 4'h1;
        end
    end

    property p_word_addr; wordMode && $past(wordMode) |-> !busAddr[0];
    endproperty
    a_word_addr: assert property (p_word_addr) else $error("odd addr");
    property p_byte_lanes;
        !wordMode && $past(!wordMode) && $past(transferStrobe)
        |-> busData[15:8] == 8'h00;
    endproperty
    a_byte_lanes: assert property (p_byte_lanes) else $error("lanes");
    property p_loop_pin; loopPin == (loopMode == 2'b10); endproperty
    a_loop_pin: assert property (p_loop_pin) else $error("loop pin");
    property p_burst_max;
        transferStrobe |-> runCnt_q < (wordMode ? 4'd6 : 4'd12);
    endproperty
    a_burst_max: assert property (p_burst_max) else $error("burst");
    property p_done;
        burstDone |-> $past(transferStrobe) && !transferStrobe && !busRequest;
    endproperty
    a_done: assert property (p_done) else $error("burst end");
    property p_grant_lat;
        $rose(transferStrobe) |-> $past(busGrantPin, 2) && busRequest;
    endproperty
    a_grant_lat: assert property (p_grant_lat) else $error("grant");
    property p_rx_thr;
        $rose(busRequest) && $past(rxActive) && !$past(txActive)
        |-> $past(fifoLevel) >= 5'd2;
    endproperty
    a_rx_thr: assert property (p_rx_thr) else $error("rx level");
    property p_tx_thr;
        $rose(busRequest) && $past(txActive) && !$past(rxActive)
        |-> $past(fifoLevel) <= 5'd11;
    endproperty
    a_tx_thr: assert property (p_tx_thr) else $error("tx level");
    property p_auto_pulse; remoteAutoInit |=> !remoteAutoInit; endproperty
    a_auto_pulse: assert property (p_auto_pulse) else $error("pulse");
endmodule

bind dpc_dma_config dpc_dma_config_monitor u_mon (
    .core_clk, .rst, .rxActive, .txActive, .fifoLevel, .busGrantPin,
    .busRequest, .busAddr, .busData, .wordMode, .transferStrobe,
    .burstDone, .loopMode, .loopPin, .remoteAutoInit
);
`default_nettype wire

// ===== dpc_dma_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dpc_dma_config_tb
    import dpc_pkg::*;
    ;
    logic        core_clk   = 1'b0;
    logic        rst        = 1'b1;
    logic        hsel       = 1'b0;
    logic        hwrite     = 1'b0;
    logic [1:0]  htrans     = 2'b00;
    logic [31:0] haddr      = 32'h0;
    logic [31:0] hwdata     = 32'h0;
    logic        rxActive   = 1'b0;
    logic        txActive   = 1'b0;
    logic [4:0]  fifoLevel  = 5'h00;
    logic [15:0] dmaAddr    = 16'h1235;
    logic [3:0]  grantDelay = 4'h0;
    logic [31:0] hrdata, busAddr, rdData;
    logic [15:0] busData;
    logic [1:0]  loopMode;
    logic        hreadyout, hresp, busRequest, busGrantPin, wordMode;
    logic        transferStrobe, burstDone, loopPin, remoteAutoInit;
    logic [4:0]  rxTab [4] = '{5'd2, 5'd4, 5'd8, 5'd12};
    int          n_errors = 0;
    int          samples_checked = 0;

    always #5 core_clk = ~core_clk;

    dpc_dma_config DUT (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
        .hresp, .rxActive, .txActive, .fifoLevel, .fifoMsByte(8'h12),
        .fifoLsByte(8'h34), .dmaAddr, .busGrantPin, .busRequest, .busAddr,
        .busData, .wordMode, .transferStrobe, .burstDone, .loopMode,
        .loopPin, .remoteAutoInit);
    dpc_bus_arbiter u_arb (.core_clk, .rst, .busRequest, .grantDelay,
        .busGrantPin);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic waitRdy();
        do begin
            @(posedge core_clk);
        end while (hreadyout !== 1'b1);
    endtask
    task automatic ahb(input logic wr, input logic [5:0] idx,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, idx, 2'b00};
        waitRdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        waitRdy();
        rdData = hrdata;
    endtask
    task automatic burst(input logic tx, input logic [4:0] thr,
                         input int beats);
        int n, cnt;
        txActive  <= tx;
        rxActive  <= !tx;
        fifoLevel <= tx ? thr + 5'd1 : thr - 5'd1;
        tick(4);
        chk(busRequest, 0);
        fifoLevel <= thr;
        cnt = 0;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (transferStrobe === 1'b1) begin
                cnt++;
            end
        end while (burstDone !== 1'b1 && n < 60);
        chk(burstDone, 1'b1);
        rxActive  <= 1'b0;
        txActive  <= 1'b0;
        fifoLevel <= 5'h00;
        chk(cnt, beats);
        tick(6);
    endtask
    task automatic wrap_up();
        $display("Checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        tick(20000);
        n_errors++;
        wrap_up();
    end

    initial begin
        logic [4:0] rx;
        int beats;
        tick(6);
        rst <= 1'b0;
        tick(1);
        chk(wordMode, 0);
        ahb(1, IDX_REMOTE_COUNT, 32'h10);
        ahb(0, IDX_STATUS, 0);
        chk(rdData[3], 1);
        ahb(1, IDX_REMOTE_START, 32'hABCD);
        tick(3);
        chk(busAddr[31:16], 16'hABCD);
        ahb(1, IDX_DATA_PATH_CFG, 32'h08);
        tick(3);
        chk(busAddr[31:16], 0);
        ahb(1, IDX_DATA_PATH_CFG, 32'h8C);
        tick(3);
        chk(busAddr[31:16], 16'hABCD);
        ahb(0, 6'h3F, 0);
        chk(rdData, 0);
        for (int i = 0; i < 16; i++) begin
            rx = rxTab[i[3:2]];
            beats = i[0] ? rx >> 1 : rx;
            grantDelay <= i[3:0];
            ahb(1, IDX_DATA_PATH_CFG, {25'h0, i[3:2], 3'b011, i[1:0]});
            ahb(0, IDX_STATUS, 0);
            chk(rdData & 32'h001F1FF0,
                {11'h0, 5'd13 - rx, 3'h0, rx, beats[3:0], 4'h0});
            chk(wordMode, i[0]);
            burst(0, rx, beats);
            burst(1, 5'd13 - rx, beats);
            chk(busData,
                !i[0] ? 16'h0034 : i[1] ? 16'h3412 : 16'h1234);
            chk(busAddr[15:0], i[0] ? 16'h1234 : 16'h1235);
        end
        ahb(1, IDX_DATA_PATH_CFG, 32'h04);
        for (int m = 0; m < 4; m++) begin
            ahb(1, IDX_TRANSMIT_CFG, m << 1);
            tick(2);
            chk(loopMode, m[1:0]);
            chk(loopPin, m == 2);
        end
        ahb(1, IDX_DATA_PATH_CFG, 32'h0C);
        tick(2);
        chk(loopMode, 0);
        // The send command runs only with auto-init remote set.
        for (int a = 0; a < 2; a++) begin
            ahb(1, IDX_DATA_PATH_CFG, 32'h0C | (a << 4));
            ahb(1, IDX_COMMAND, 32'h1);
            beats = 0;
            repeat (4) begin
                @(posedge core_clk);
                if (remoteAutoInit === 1'b1) begin
                    beats++;
                end
            end
            chk(beats, a);
            ahb(0, IDX_STATUS, 0);
            chk(rdData[2], !a);
            ahb(1, IDX_STATUS, 32'h4);
        end
        // A reset in mid-run brings back the power-up configuration.
        ahb(1, IDX_DATA_PATH_CFG, 32'h09);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        chk(wordMode, 0);
        chk(busRequest, 0);
        ahb(1, IDX_REMOTE_START, 32'h5A5A);
        tick(3);
        chk(busAddr[31:16], 16'h5A5A);
        wrap_up();
    end
endmodule
`default_nettype wire
